// >>> hw/fch_host.sv
// fch_host: two-channel flash card serial host with a classic wishbone register slave
//
// Contract
// - data port: write sends, read returns received
// - status bits 0/3 report crc result
// - status bits 1/4 show shifting
// - status bits 2/5 show card irq
// - twelve pending sources, each with enable
// - write one to clear pending edge bit (bits 0-7)
// - bits 0-3 primary shift/irq edges
// - bits 4-7 secondary shift/irq edges
// - bits 8-11 buffer full/empty levels
// - any stall freezes shared serial clock
// - unread receive word stops serial clock once the next word is complete
// - empty transmit word stops serial clock once the current word is shifted out
// - opcode 0001 reads bus-state card
// - send command, receive response, then drive
// - first tx word remainder left-justified
// - first rx word remainder right-justified
// - bit count loads, reads back remaining
// - bit 22 drives cmd line after response
// - bit 23 drives data line after command
`timescale 1ns/1ns
`default_nettype none

module fch_host
	import fch_pkg::*;
(
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic ce,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// card pins
	input wire fch_pin_i_t pins_i,
	output fch_pin_o_t pins_o
);

	fch_state_t st;
	fch_state_t next_st;
	logic acc;
	logic stall;
	logic active;
	logic rise;
	logic fall;
	logic [7:0] adr;
	logic [31:0] wmask;
	logic [31:0] cv;
	logic [7:0] clr;
	logic [11:0] pend_all;
	logic [11:0] pend_now;

	// bits of the word now being shifted: remainder first, then full words
	function automatic logic [5:0] fch_chunk(input logic [15:0] cnt);
		return (cnt[4:0] == 5'h00) ? WORD_BITS : {1'b0, cnt[4:0]};
	endfunction : fch_chunk

	function automatic logic [15:0] fch_crc(input logic [15:0] crc, input logic b);
		return {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? CRC_POLY : 16'h0000);
	endfunction : fch_crc

	function automatic logic [31:0] fch_cmd_rd(input fch_if_t f);
		return {8'h00, f.ddat, f.dcmd, 1'b0, f.nbs, f.op, f.bitcnt};
	endfunction : fch_cmd_rd

	assign adr = {wb_adr_i[7:2], 2'h0};
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign pend_now = {~st.ifc[1].tx_full, st.ifc[1].rx_full, ~st.ifc[0].tx_full,
		st.ifc[0].rx_full, st.pend};

	always_comb begin
		next_st = st;
		clr = 8'h00;
		cv = 32'h0000_0000;
		stall = 1'b0;
		active = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		pend_all = 12'h000;
		acc = wb_cyc_i & wb_stb_i & ~st.ack;
		next_st.ack = acc;

		// two-stage synchronisers for the card-side inputs
		next_st.ifc[0].in_s1 = pins_i.dat_in;
		next_st.ifc[1].in_s1 = pins_i.cmd_in;
		for (int i = 0; i < 2; i++) begin
			next_st.ifc[i].in_bit = st.ifc[i].in_s1;
			next_st.ifc[i].irq_s1 = pins_i.card_irq[i];
			next_st.ifc[i].irq_lvl = st.ifc[i].irq_s1;
			next_st.ifc[i].irq_prev = st.ifc[i].irq_lvl;
		end

		if (acc && !wb_we_i) begin
			case (adr)
				OFS_DATA_P: begin
					next_st.rdata = st.ifc[0].rx_word;
					next_st.ifc[0].rx_full = 1'b0;
				end
				OFS_DATA_S: begin
					next_st.rdata = st.ifc[1].rx_word;
					next_st.ifc[1].rx_full = 1'b0;
				end
				OFS_STAT: begin
					next_st.rdata = 32'h0000_0000;
					for (int i = 0; i < 2; i++) begin
						next_st.rdata[i * ST_STRIDE + ST_CRC] = st.ifc[i].crc_ok;
						next_st.rdata[i * ST_STRIDE + ST_SHIFT] = st.ifc[i].shifting;
						next_st.rdata[i * ST_STRIDE + ST_IRQ] = st.ifc[i].irq_lvl;
					end
				end
				OFS_PEND: next_st.rdata = {20'h00000, pend_now};
				OFS_INTEN: next_st.rdata = {20'h00000, st.inten};
				OFS_CMD_P: next_st.rdata = fch_cmd_rd(st.ifc[0]);
				OFS_CMD_S: next_st.rdata = fch_cmd_rd(st.ifc[1]);
				OFS_CFG: next_st.rdata = {23'h000000, st.card_type, st.div};
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end

		if (acc && wb_we_i) begin
			case (adr)
				OFS_DATA_P, OFS_DATA_S: begin
					for (int i = 0; i < 2; i++) begin
						if (adr == ((i == 0) ? OFS_DATA_P : OFS_DATA_S)) begin
							next_st.ifc[i].tx_word = (st.ifc[i].tx_word & ~wmask) |
								(wb_dat_i & wmask);
							next_st.ifc[i].tx_full = 1'b1;
						end
					end
				end
				OFS_INTEN: begin
					next_st.inten = (st.inten & ~wmask[11:0]) | (wb_dat_i[11:0] & wmask[11:0]);
				end
				OFS_ICLR: clr = wb_dat_i[7:0] & wmask[7:0];
				OFS_CMD_P, OFS_CMD_S: begin
					for (int i = 0; i < 2; i++) begin
						if (adr == ((i == 0) ? OFS_CMD_P : OFS_CMD_S)) begin
							cv = (fch_cmd_rd(st.ifc[i]) & ~wmask) | (wb_dat_i & wmask);
							next_st.ifc[i].bitcnt = cv[15:0];
							next_st.ifc[i].op = cv[CMD_OP_LSB +: 4];
							next_st.ifc[i].nbs = cv[CMD_NBS_BIT];
							next_st.ifc[i].dcmd = cv[CMD_DCMD_BIT];
							next_st.ifc[i].ddat = cv[CMD_DDAT_BIT];
							if (cv[15:0] != 16'h0000 && !st.ifc[i].shifting) begin
								next_st.ifc[i].shifting = 1'b1;
								next_st.ifc[i].shreg = 32'h0000_0000;
								next_st.ifc[i].hold = 1'b0;
								next_st.ifc[i].crc = 16'h0000;
								if (cv[CMD_OP_LSB + OP_TX_BIT]) begin
									next_st.ifc[i].wbits = 6'h00;
								end else begin
									next_st.ifc[i].wbits = fch_chunk(cv[15:0]);
									// the card drives this line now
									if (i == 0) begin
										next_st.dat_hold = 1'b0;
									end else begin
										next_st.cmd_hold = 1'b0;
									end
								end
							end
						end
					end
				end
				OFS_CFG: begin
					next_st.div = (st.div & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
					if (wb_sel_i[1]) begin
						next_st.card_type = wb_dat_i[CFG_TYPE_BIT];
					end
				end
				default: begin
				end
			endcase
		end

		// shared serial clock divider
		for (int i = 0; i < 2; i++) begin
			active = active | st.ifc[i].shifting;
			stall = stall | (st.ifc[i].hold & st.ifc[i].rx_full);
			stall = stall | (st.ifc[i].shifting & st.ifc[i].op[OP_TX_BIT] &
				(st.ifc[i].wbits == 6'h00) & ~st.ifc[i].tx_full);
		end
		// a high half still runs out when work ends, so no clock half is ever cut short
		if (!active && !st.po.sclk) begin
			next_st.po.sclk = 1'b0;
			next_st.divcnt = 8'h00;
		end else if (!stall) begin
			if (st.divcnt >= st.div) begin
				next_st.divcnt = 8'h00;
				next_st.po.sclk = ~st.po.sclk;
				rise = ~st.po.sclk;
				fall = st.po.sclk;
			end else begin
				next_st.divcnt = st.divcnt + 8'h01;
			end
		end

		for (int i = 0; i < 2; i++) begin
			if (st.ifc[i].shifting && next_st.ifc[i].op[OP_TX_BIT]) begin
				// transmit: a bit is held from one falling edge to the next
				if (fall && next_st.ifc[i].wbits != 6'h00) begin
					next_st.ifc[i].shreg = {next_st.ifc[i].shreg[30:0], 1'b0};
					next_st.ifc[i].wbits = next_st.ifc[i].wbits - 6'h01;
					next_st.ifc[i].bitcnt = next_st.ifc[i].bitcnt - 16'h0001;
					if (next_st.ifc[i].bitcnt == 16'h0000) begin
						next_st.ifc[i].shifting = 1'b0;
						if (i == 1) begin
							next_st.dat_hold = next_st.ifc[i].ddat;
						end
					end
				end
				if (next_st.ifc[i].shifting && next_st.ifc[i].wbits == 6'h00 &&
					next_st.ifc[i].tx_full) begin
					next_st.ifc[i].shreg = next_st.ifc[i].tx_word;
					next_st.ifc[i].wbits = fch_chunk(next_st.ifc[i].bitcnt);
					next_st.ifc[i].tx_full = 1'b0;
				end
			end else if (st.ifc[i].shifting) begin
				// receive: sample on the rising edge we drive out
				if (rise && next_st.ifc[i].wbits != 6'h00 && !next_st.ifc[i].hold) begin
					// right-justified by shifting in at lsb
					next_st.ifc[i].shreg = {next_st.ifc[i].shreg[30:0], st.ifc[i].in_bit};
					next_st.ifc[i].crc = fch_crc(next_st.ifc[i].crc, st.ifc[i].in_bit);
					next_st.ifc[i].wbits = next_st.ifc[i].wbits - 6'h01;
					next_st.ifc[i].bitcnt = next_st.ifc[i].bitcnt - 16'h0001;
					next_st.ifc[i].hold = (next_st.ifc[i].wbits == 6'h00);
				end
				if (next_st.ifc[i].hold && !next_st.ifc[i].rx_full) begin
					next_st.ifc[i].rx_word = next_st.ifc[i].shreg;
					next_st.ifc[i].rx_full = 1'b1;
					next_st.ifc[i].hold = 1'b0;
					next_st.ifc[i].shreg = 32'h0000_0000;
					if (next_st.ifc[i].bitcnt == 16'h0000) begin
						next_st.ifc[i].shifting = 1'b0;
						// zero residue means the crc matched
						next_st.ifc[i].crc_ok = (next_st.ifc[i].crc == 16'h0000);
						if (i == 1) begin
							next_st.cmd_hold = next_st.ifc[i].dcmd;
						end
					end else begin
						next_st.ifc[i].wbits = fch_chunk(next_st.ifc[i].bitcnt);
					end
				end
			end
		end

		// line drive: shifting out, else the held drive level
		if (next_st.ifc[1].shifting && next_st.ifc[1].op[OP_TX_BIT]) begin
			next_st.po.cmd_out = next_st.ifc[1].shreg[31];
			next_st.po.cmd_oe_n = 1'b0;
		end else begin
			next_st.po.cmd_out = 1'b1;
			next_st.po.cmd_oe_n = ~next_st.cmd_hold;
		end
		if (next_st.ifc[0].shifting && next_st.ifc[0].op[OP_TX_BIT]) begin
			next_st.po.dat_out = next_st.ifc[0].shreg[31];
			next_st.po.dat_oe_n = 1'b0;
		end else begin
			next_st.po.dat_out = 1'b1;
			next_st.po.dat_oe_n = ~next_st.dat_hold;
		end

		for (int i = 0; i < 2; i++) begin
			next_st.po.bus_state[i] = next_st.ifc[i].nbs;
			// sticky edges; a new edge beats a clear
			next_st.pend[i * PD_STRIDE +: PD_STRIDE] =
				(st.pend[i * PD_STRIDE +: PD_STRIDE] & ~clr[i * PD_STRIDE +: PD_STRIDE]) |
				{st.ifc[i].irq_lvl & ~st.ifc[i].irq_prev, ~st.ifc[i].irq_lvl & st.ifc[i].irq_prev,
				next_st.ifc[i].shifting & ~st.ifc[i].shifting,
				~next_st.ifc[i].shifting & st.ifc[i].shifting};
		end

		pend_all = {~next_st.ifc[1].tx_full, next_st.ifc[1].rx_full, ~next_st.ifc[0].tx_full,
			next_st.ifc[0].rx_full, next_st.pend};
		next_st.po.irq[0] = |(pend_all[3:0] & next_st.inten[3:0]);
		next_st.po.irq[1] = |(pend_all[7:4] & next_st.inten[7:4]);
		next_st.po.irq[2] = |(pend_all[9:8] & next_st.inten[9:8]);
		next_st.po.irq[3] = |(pend_all[11:10] & next_st.inten[11:10]);
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st <= '0;
			st.div <= CFG_DIV_RST;
			st.po.cmd_oe_n <= 1'b1;
			st.po.dat_oe_n <= 1'b1;
			st.po.cmd_out <= 1'b1;
			st.po.dat_out <= 1'b1;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign wb_dat_o = st.rdata;
	assign wb_ack_o = st.ack;
	assign pins_o = st.po;

endmodule : fch_host

`default_nettype wire

// >>> hw/fch_pkg.sv
// fch_pkg: register map, field layout and carrier types of the flash card serial host
package fch_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] OFS_DATA_P = 8'h00;
	localparam logic [7:0] OFS_DATA_S = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_PEND = 8'h0C;
	localparam logic [7:0] OFS_INTEN = 8'h10;
	localparam logic [7:0] OFS_ICLR = 8'h14;
	localparam logic [7:0] OFS_CMD_P = 8'h18;
	localparam logic [7:0] OFS_CMD_S = 8'h1C;
	localparam logic [7:0] OFS_CFG = 8'h20;

	// command register fields
	localparam int unsigned CMD_OP_LSB = 16;
	localparam int unsigned CMD_NBS_BIT = 20;
	localparam int unsigned CMD_DCMD_BIT = 22;
	localparam int unsigned CMD_DDAT_BIT = 23;
	localparam int unsigned OP_TX_BIT = 1;
	localparam logic [3:0] OP_READ_BS = 4'h1;

	// status register: three bits per interface
	localparam int unsigned ST_STRIDE = 3;
	localparam int unsigned ST_CRC = 0;
	localparam int unsigned ST_SHIFT = 1;
	localparam int unsigned ST_IRQ = 2;

	// pending bits: four edge bits per interface, then buffer levels
	localparam int unsigned PD_STRIDE = 4;
	localparam int unsigned N_IRQ_SRC = 12;

	// configuration register
	localparam int unsigned CFG_TYPE_BIT = 8;
	localparam logic [7:0] CFG_DIV_RST = 8'h03;

	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [5:0] WORD_BITS = 6'h20;

	typedef struct packed {
		logic [15:0] bitcnt;
		logic [3:0] op;
		logic nbs;
		logic dcmd;
		logic ddat;
		logic shifting;
		logic tx_full;
		logic [31:0] tx_word;
		logic [31:0] shreg;
		logic [5:0] wbits;
		logic hold;
		logic rx_full;
		logic [31:0] rx_word;
		logic [15:0] crc;
		logic crc_ok;
		logic irq_s1;
		logic irq_lvl;
		logic irq_prev;
		logic in_s1;
		logic in_bit;
	} fch_if_t;

	typedef struct packed {
		logic cmd_in;
		logic dat_in;
		logic [1:0] card_irq;
	} fch_pin_i_t;

	typedef struct packed {
		logic sclk;
		logic cmd_out;
		logic cmd_oe_n;
		logic dat_out;
		logic dat_oe_n;
		logic [1:0] bus_state;
		logic [3:0] irq;
	} fch_pin_o_t;

	typedef struct packed {
		fch_if_t [1:0] ifc;
		logic [7:0] pend;
		logic [11:0] inten;
		logic [7:0] div;
		logic [7:0] divcnt;
		logic card_type;
		logic cmd_hold;
		logic dat_hold;
		logic ack;
		logic [31:0] rdata;
		fch_pin_o_t po;
	} fch_state_t;

endpackage : fch_pkg

// >>> verif/fch_host_asserts.sv
// fch_host_asserts: port-level checks of the flash card serial host
`timescale 1ns/1ns
`default_nettype none
module fch_host_asserts
	import fch_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic ce,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// pins
	input wire fch_pin_i_t pins_i,
	input wire fch_pin_o_t pins_o
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	logic take;
	logic wr_cmd;
	logic [3:0] en_lo;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
	assign wr_cmd = take && wb_we_i && wb_adr_i == OFS_CMD_P && wb_sel_i[2];
	// shadow of the low enables so the line check needs no internal view
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			en_lo <= 4'h0;
		end else if (take && wb_we_i && wb_adr_i == OFS_INTEN && wb_sel_i[0]) begin
			en_lo <= wb_dat_i[3:0];
		end
	end
	a_ack_after_take: assert property (take |=> wb_ack_o)
		else $error("no ack after request");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(take))
		else $error("ack without request");
	a_unmapped_zero: assert property (wb_ack_o && $past(wb_adr_i) == 8'h30 &&
		!$past(wb_we_i) |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	a_sclk_half_len: assert property ($changed(pins_o.sclk) |=> $stable(pins_o.sclk) [*3])
		else $error("serial clock half too short");
	a_bus_state_cmd: assert property (wr_cmd |-> ##2
		pins_o.bus_state[0] == $past(wb_dat_i[CMD_NBS_BIT], 2)) else $error("bus state wrong");
	a_irq_needs_en: assert property (en_lo == 4'h0 && $past(en_lo) == 4'h0 |->
		!pins_o.irq[0]) else $error("irq line without enable");
	a_reset_lines_off: assert property (disable iff (1'b0) srst |=>
		!pins_o.sclk && pins_o.dat_oe_n && pins_o.cmd_oe_n) else $error("lines driven in reset");
	c_write: cover property (take && wb_we_i);
	c_sclk: cover property ($rose(pins_o.sclk));
	c_irq: cover property (pins_o.irq[0]);
endmodule : fch_host_asserts
`default_nettype wire

// >>> verif/fch_card_model.sv
// fch_card_model: behavioural flash card on the primary data line
`timescale 1ns/1ns
`default_nettype none
module fch_card_model
	import fch_pkg::*;
(
	// bench control
	input wire logic restart,
	input wire logic [31:0] pattern,
	input wire logic [1:0] irq_req,
	// card pins
	input wire fch_pin_o_t po,
	output fch_pin_i_t pi,
	output logic [31:0] seen
);
	logic [4:0] idx;
	logic line;
	assign line = po.dat_oe_n ? pattern[~idx] : po.dat_out;
	assign pi.dat_in = line;
	// released command line floats to its pull-up
	assign pi.cmd_in = po.cmd_oe_n ? 1'b1 : po.cmd_out;
	assign pi.card_irq = irq_req;
	always @(negedge po.sclk or posedge restart) begin
		if (restart) begin
			idx <= 5'h0;
		end else begin
			idx <= idx + 5'h1;
		end
	end
	always @(posedge po.sclk) begin
		seen <= {seen[30:0], line};
	end
endmodule : fch_card_model
`default_nettype wire

// >>> verif/tb_flash_card_serial_host.sv
// tb_flash_card_serial_host: directed bench for the flash card serial host
`timescale 1ns/1ns
`default_nettype none
module tb_flash_card_serial_host;
	import fch_pkg::*;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] rd;
	logic ack;
	logic restart = 1'b1;
	logic [1:0] irq_req = 2'b00;
	logic [31:0] seen;
	fch_pin_i_t pi;
	fch_pin_o_t po;
	int fails = 0;
	int checks_done = 0;
	int rises = 0;
	always #50 clk_sys = ~clk_sys;
	always @(posedge po.sclk) rises++;
	fch_host i_dut (.clk_sys(clk_sys), .srst(srst), .ce(1'b1), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .pins_i(pi), .pins_o(po));
	fch_card_model i_card (.restart(restart), .pattern(32'hC3A51E69), .irq_req(irq_req),
		.po(po), .pi(pi), .seen(seen));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) fails++;
		rd = rdat;
		cyc <= 1'b0;
		@(posedge clk_sys);
	endtask : bus
	task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
		int n;
		n = 0;
		do begin
			bus(1'b0, a, 32'h0);
			n++;
		end while (rd[b] !== v && n < 500);
		chk(32'(rd[b]), 32'(v));
	endtask : wait_bit
	task automatic t_regs;
		bus(1'b0, OFS_STAT, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, OFS_PEND, 32'h0);
		chk(rd & 32'hFF, 32'h0);
		bus(1'b1, OFS_INTEN, 32'hFFFFFFFF);
		bus(1'b0, OFS_INTEN, 32'h0);
		chk(rd, 32'h00000FFF);
		bus(1'b1, OFS_INTEN, 32'h0);
		bus(1'b0, 8'h30, 32'h0);
		chk(rd, 32'h0);
	endtask : t_regs
	task automatic t_bs;
		bus(1'b1, OFS_CMD_P, 32'h00110000);
		bus(1'b1, OFS_CMD_S, 32'h00100000);
		chk(32'(po.bus_state), 32'h3);
		bus(1'b0, OFS_CMD_P, 32'h0);
		chk(rd, 32'h00110000);
		bus(1'b1, OFS_CMD_P, 32'h0);
		bus(1'b1, OFS_CMD_S, 32'h0);
		chk(32'(po.bus_state), 32'h0);
	endtask : t_bs
	task automatic t_irq;
		irq_req <= 2'b10;
		repeat (5) @(posedge clk_sys);
		bus(1'b0, OFS_STAT, 32'h0);
		chk(rd & 32'h24, 32'h20);
		irq_req <= 2'b00;
		repeat (5) @(posedge clk_sys);
		bus(1'b0, OFS_PEND, 32'h0);
		chk(rd & 32'hFF, 32'hC0);
		bus(1'b1, OFS_ICLR, 32'h40);
		bus(1'b0, OFS_PEND, 32'h0);
		chk(rd & 32'hFF, 32'h80);
		bus(1'b1, OFS_ICLR, 32'hFF);
	endtask : t_irq
	task automatic t_tx;
		int r0;
		r0 = rises;
		bus(1'b1, OFS_CMD_P, 32'h00860008);
		repeat (40) @(posedge clk_sys);
		chk(32'(rises - r0), 32'h0);
		bus(1'b1, OFS_DATA_P, 32'hA5000000);
		wait_bit(OFS_STAT, ST_SHIFT, 1'b0);
		chk(32'(seen[7:0]), 32'hA5);
		bus(1'b0, OFS_PEND, 32'h0);
		chk(rd & 32'h3, 32'h3);
		bus(1'b1, OFS_INTEN, 32'h2);
		repeat (2) @(posedge clk_sys);
		chk(32'(po.irq[0]), 32'h1);
		bus(1'b1, OFS_ICLR, 32'h1);
		bus(1'b0, OFS_PEND, 32'h0);
		chk(rd & 32'h3, 32'h2);
		bus(1'b1, OFS_ICLR, 32'h2);
		repeat (2) @(posedge clk_sys);
		chk(32'(po.irq[0]), 32'h0);
		bus(1'b1, OFS_INTEN, 32'h0);
	endtask : t_tx
	task automatic t_rx;
		int r0;
		restart <= 1'b1;
		bus(1'b1, OFS_CMD_P, 32'h00000040);
		restart <= 1'b0;
		wait_bit(OFS_PEND, 8, 1'b1);
		repeat (400) @(posedge clk_sys);
		r0 = rises;
		repeat (100) @(posedge clk_sys);
		chk(32'(rises - r0), 32'h0);
		bus(1'b0, OFS_DATA_P, 32'h0);
		chk(rd, 32'hC3A51E69);
		wait_bit(OFS_PEND, 8, 1'b1);
		bus(1'b0, OFS_DATA_P, 32'h0);
		chk(rd, 32'hC3A51E69);
		wait_bit(OFS_STAT, ST_SHIFT, 1'b0);
	endtask : t_rx
	task automatic t_hs;
		restart <= 1'b1;
		bus(1'b1, OFS_CMD_P, 32'h00010010);
		restart <= 1'b0;
		wait_bit(OFS_PEND, 8, 1'b1);
		bus(1'b0, OFS_DATA_P, 32'h0);
		chk(rd, 32'h0000C3A5);
		wait_bit(OFS_STAT, ST_SHIFT, 1'b0);
	endtask : t_hs
	task automatic t_sec;
		bus(1'b1, OFS_CMD_S, 32'h00060008);
		wait_bit(OFS_PEND, 11, 1'b1);
		bus(1'b1, OFS_DATA_S, 32'hA5000000);
		wait_bit(OFS_STAT, 4, 1'b0);
		bus(1'b1, OFS_CMD_S, 32'h00400008);
		wait_bit(OFS_STAT, 4, 1'b1);
		wait_bit(OFS_PEND, 10, 1'b1);
		bus(1'b0, OFS_DATA_S, 32'h0);
		chk(rd, 32'h000000FF);
		wait_bit(OFS_STAT, 4, 1'b0);
		chk(32'(po.cmd_oe_n), 32'h0);
		chk(32'(po.dat_oe_n), 32'h1);
	endtask : t_sec
	task automatic give_verdict;
		if (fails == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		restart <= 1'b0;
		@(posedge clk_sys);
		bus(1'b1, OFS_CFG, 32'h00000103);
		bus(1'b0, OFS_CFG, 32'h0);
		chk(rd, 32'h00000103);
		t_regs();
		t_bs();
		t_irq();
		t_tx();
		t_rx();
		t_hs();
		t_sec();
		give_verdict();
	end
	initial begin
		#2000000;
		fails++;
		give_verdict();
	end
endmodule : tb_flash_card_serial_host
bind fch_host fch_host_asserts i_chk (.clk_sys(clk_sys), .srst(srst), .ce(ce),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.pins_i(pins_i), .pins_o(pins_o));
`default_nettype wire
